// ### tb_usart_status_baud_data.sv
// Self-checking bench for the serial channel with a remote device model.
// Assumes usart_pkg and usart_channel are compiled first.
`timescale 1ns/1ps
module tb_usart_status_baud_data;
  localparam logic [7:0] CT = usart_pkg::CTRL_ADDR;
  localparam logic [7:0] ST = usart_pkg::STAT_ADDR;
  localparam logic [7:0] BD = usart_pkg::BAUD_ADDR;
  localparam logic [7:0] DT = usart_pkg::DATA_ADDR;
  localparam logic [7:0] IS = usart_pkg::IRQ_STAT_ADDR;
  localparam logic [7:0] IM = usart_pkg::IRQ_MASK_ADDR;
  logic       core_clk;
  logic       reset;
  logic       clk_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] rdata;
  logic       stop_mode;
  logic       rx_line;
  logic       tx_line;
  logic       shift_clk;
  logic       shift_clk_oe;
  logic       irq;
  int         error_cnt;
  int         compares;
  int         cycles;
  int         seed;
  int         n;
  logic [7:0] d;
  logic [7:0] b;
  logic [7:0] baud;
  logic       ok;
  logic       prev;
  int         rises[$];

  usart_channel u_dut (
    .core_clk(core_clk), .reset(reset), .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .rx_line(rx_line), .stop_mode(stop_mode), .tx_line(tx_line),
    .sync_shift_clock(shift_clk), .sync_shift_clock_oe(shift_clk_oe), .irq(irq));

  usart_remote u_remote (.core_clk(core_clk), .tx_line(tx_line), .rx_line(rx_line));

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  ////////////////////////////////////////
  // Bus cycles and comparisons
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    addr  <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    rd(a, d);
    check(d & m, e);
  endtask

  task automatic wait_stat(input logic [7:0] m);
    int k;
    k = 0;
    d = 8'h00;
    while ((d & m) == 8'h00 && k < 1000)
    begin
      rd(ST, d);
      k++;
    end
    repeat (2) @(posedge core_clk);
  endtask

  task automatic stop_test();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////
  // Scenarios
  initial
  begin
    seed = 22245;
    error_cnt = 0;
    compares = 0;
    cycles = 0;
    reset = 1'b1;
    clk_en = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    stop_mode = 1'b0;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    chk(BD, 8'hFF, 8'hFF);
    chk(DT, 8'hFF, 8'hFF);
    chk(ST, 8'hFF, 8'h80);
    chk(8'h00, 8'hFF, 8'h00);
    $display("test reset_values done");
    wr(IM, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      b = 8'($random(seed));
      baud = 8'(1 + ($unsigned($random(seed)) % 3));
      n = (int'(baud) + 1) * (i[0] ? 8 : 16);
      wr(BD, baud);
      stop_mode <= 1'($random(seed));
      wr(CT, {6'h03, 1'b0, i[0]});
      chk(BD, 8'hFF, baud);
      u_remote.send(b, n, 1'b0, 1'b0, 1'b0);
      wait_stat(8'h20);
      check(d & 8'h27, 8'h20);
      check({7'h00, irq}, 8'h01);
      chk(DT, 8'hFF, b);
      wr(IS, 8'hFF);
      repeat (2) @(posedge core_clk);
      check({7'h00, irq}, 8'h00);
      chk(ST, 8'h80, 8'h80);
      b = 8'($random(seed));
      wr(DT, b);
      u_remote.recv(n, d, ok);
      check({d[7:1], ok}, {b[7:1], 1'b1});
      check(d, b);
    end
    $display("test async_rates done");
    wr(BD, 8'h01);
    wr(CT, 8'h2C);
    for (int k = 0; k < 3; k++)
    begin
      b = 8'($random(seed));
      u_remote.send(b, 32, 1'b1, k == 1, k == 2);
      wait_stat(8'h20);
      check(d & 8'h03, {6'h00, k == 2, k == 1});
      chk(DT, 8'hFF, b);
      chk(ST, 8'h27, 8'h00);
    end
    $display("test error_flags done");
    wr(CT, 8'h0C);
    b = 8'($random(seed));
    u_remote.send(b, 32, 1'b0, 1'b0, 1'b0);
    u_remote.send(~b, 32, 1'b0, 1'b0, 1'b0);
    repeat (8) @(posedge core_clk);
    chk(ST, 8'h24, 8'h24);
    u_remote.send(b ^ 8'h5A, 32, 1'b0, 1'b0, 1'b0);
    repeat (8) @(posedge core_clk);
    chk(DT, 8'hFF, b);
    chk(ST, 8'h24, 8'h00);
    $display("test overrun done");
    wr(CT, 8'h08);
    wr(ST, 8'hE0);
    wr(IS, 8'hFF);
    wr(IM, 8'h04);
    stop_mode <= 1'b1;
    u_remote.set_line(1'b0);
    repeat (6) @(posedge core_clk);
    chk(ST, 8'h10, 8'h10);
    check({7'h00, irq}, 8'h01);
    u_remote.set_line(1'b1);
    stop_mode <= 1'b0;
    repeat (6) @(posedge core_clk);
    wr(ST, 8'hE0);
    wr(IS, 8'h04);
    repeat (2) @(posedge core_clk);
    chk(ST, 8'h10, 8'h00);
    for (int m = 0; m < 2; m++)
    begin
      wr(CT, m == 0 ? 8'h40 : 8'hC0);
      stop_mode <= 1'b1;
      u_remote.set_line(1'b0);
      repeat (6) @(posedge core_clk);
      chk(ST, 8'h10, 8'h00);
      check({7'h00, irq}, 8'h00);
      u_remote.set_line(1'b1);
      stop_mode <= 1'b0;
    end
    $display("test wake done");
    wr(BD, 8'h02);
    wr(CT, 8'h46);
    u_remote.set_line(1'b0);
    repeat (2) @(posedge core_clk);
    check({7'h00, shift_clk_oe}, 8'h01);
    chk(ST, 8'h80, 8'h80);
    wr(DT, 8'h3C);
    rises.delete();
    prev = 1'b0;
    for (int c = 0; c < 200; c++)
    begin
      @(posedge core_clk);
      if (shift_clk === 1'b1 && prev === 1'b0)
        rises.push_back(c);
      prev = shift_clk;
    end
    check(8'(rises.size()), 8'h08);
    if (rises.size() > 1)
      check(8'(rises[1] - rises[0]), 8'h06);
    chk(ST, 8'h20, 8'h20);
    chk(DT, 8'hFF, 8'h00);
    u_remote.set_line(1'b1);
    $display("test sync_master done");
    wr(ST, 8'h00);
    chk(ST, 8'hD0, 8'h00);
    wr(ST, 8'h08);
    repeat (2) @(posedge core_clk);
    chk(ST, 8'hFF, 8'h80);
    chk(DT, 8'hFF, 8'hFF);
    chk(BD, 8'hFF, 8'h02);
    chk(CT, 8'hFF, 8'h46);
    $display("test soft_reset done");
    clk_en <= 1'b0;
    wr(BD, 8'h55);
    clk_en <= 1'b1;
    chk(BD, 8'hFF, 8'h02);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    chk(BD, 8'hFF, 8'hFF);
    chk(ST, 8'hFF, 8'h80);
    $display("test freeze_reset done");
    stop_test();
  end
endmodule

// ### usart_channel.sv
// Serial channel: status flags, soft reset, baud divisor, shared data port.
// Assumes one clock, register port strobes synchronous to core_clk, rx_line asynchronous.
// Operation
// - Low rx pin in stop mode sets wake
// - Wake sets only in asynchronous mode
// - Soft reset bit resets channel, self-clears
// - Overrun flag set; frames dropped while set
// - Receive buffer read clears overrun flag
// - Framing error follows zero stop bit
// - Parity error when checking enabled and bad
// - Divisor, reset all ones, sets rates
// - Data port: write transmits, read receives
// - Sync master write starts clock always
// - Double speed affects asynchronous mode only
// - Empty flag reads one; zero write clears
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module usart_channel #(
  parameter int ADDR_W = 8
) (
  input  wire logic              core_clk,           // System clock
  input  wire logic              reset,              // Synchronous reset, active high
  input  wire logic              clk_en,             // Freezes all state while low
  input  wire logic [ADDR_W-1:0] addr,               // Register address
  input  wire logic [7:0]        wdata,              // Write data
  input  wire logic              wr_en,              // Write strobe
  input  wire logic              rd_en,              // Read strobe
  output logic      [7:0]        rdata,              // Read data, cycle after rd_en
  input  wire logic              rx_line,            // Receive pin
  input  wire logic              stop_mode,          // Processor in stop mode
  output logic                   tx_line,            // Transmit pin
  output logic                   sync_shift_clock,   // Shift clock out
  output logic                   sync_shift_clock_oe,// Shift clock drive enable
  output logic                   irq                 // Level interrupt
);

  initial
  begin
    if (ADDR_W < 8)
      $error("ADDR_W must be at least 8");
  end

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_e;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    return a == ADDR_W'(off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers and decode
  logic [7:0]      ctrl_q, baud_q, rx_buf_q, tx_buf_q, tx_sh_q, rx_sh_q, srx_q, rdata_q;
  logic            tx_empty_q, txc_q, wake_q, srst_q, overrun_q, frame_err_q, parity_err_q, rx_full_q, tx_full_q;
  logic            rx_m1_q, rx_m2_q, rx_m3_q, rx_s_q;
  logic            txd_q, sclk_q, sclk_oe_q, irq_q, tx_par_q, rx_par_q, rx_par_err_q;
  logic [7:0]      div_cnt_q;
  logic [4:0]      tph_q, rph_q;
  logic [2:0]      tbit_q, rbit_q;
  tx_state_e       tx_st_q;
  rx_state_e       rx_st_q;

  localparam int IRQ_W = usart_pkg::IR_W;
  logic [IRQ_W-1:0] irq_stat_q, irq_mask_q;
  // Soft reset waits for the clock enable so a frozen channel keeps its state
  wire chan_rst   = reset | (srst_q & clk_en);
  wire wr_ctrl    = wr_en & hit(addr, usart_pkg::CTRL_ADDR);
  wire wr_stat    = wr_en & hit(addr, usart_pkg::STAT_ADDR);
  wire wr_baud    = wr_en & hit(addr, usart_pkg::BAUD_ADDR);
  wire wr_data    = wr_en & hit(addr, usart_pkg::DATA_ADDR);
  wire wr_istat   = wr_en & hit(addr, usart_pkg::IRQ_STAT_ADDR);
  wire wr_imask   = wr_en & hit(addr, usart_pkg::IRQ_MASK_ADDR);
  wire rd_data    = rd_en & hit(addr, usart_pkg::DATA_ADDR);
  wire [1:0] mode = ctrl_q[usart_pkg::CT_MODE_HI:usart_pkg::CT_MODE_LO];
  wire is_async   = mode == usart_pkg::MODE_ASYNC;
  wire tx_en      = ctrl_q[usart_pkg::CT_TX_EN];
  wire rxe        = ctrl_q[usart_pkg::CT_RXE];
  wire par_en     = ctrl_q[usart_pkg::CT_PAR_EN];
  wire par_odd    = ctrl_q[usart_pkg::CT_PAR_ODD];
  wire sync_mst   = !is_async & ctrl_q[usart_pkg::CT_MASTER];

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ctrl_q     <= usart_pkg::CTRL_RST;
      baud_q     <= usart_pkg::BAUD_RST;
      irq_mask_q <= IRQ_W'(usart_pkg::MASK_RST);
    end
    else if (clk_en)
    begin
      if (wr_ctrl)
        ctrl_q <= wdata;
      if (wr_baud)
        baud_q <= wdata;
      if (wr_imask)
        irq_mask_q <= wdata[IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Soft reset pulse and rx pin synchroniser
  always_ff @(posedge core_clk)
  begin
    if (reset)
      srst_q <= 1'b0;
    else if (clk_en)
      srst_q <= wr_stat & wdata[usart_pkg::ST_SRST] & !srst_q;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      {rx_m1_q, rx_m2_q, rx_m3_q, rx_s_q} <= 4'hF;
    end
    else if (clk_en)
    begin
      rx_m1_q <= rx_line;
      rx_m2_q <= rx_m1_q;
      rx_m3_q <= rx_m2_q;
      if (rx_m2_q == rx_m3_q)
        rx_s_q <= rx_m3_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Baud tick: one every divisor+1 cycles, spb ticks per bit
  wire       tick = div_cnt_q >= baud_q;
  wire [4:0] spb  = !is_async ? usart_pkg::OS_SYNC :
                    ctrl_q[usart_pkg::CT_DOUBLE_SPEED] ? usart_pkg::OS_DOUBLE : usart_pkg::OS_NORMAL;
  wire       t_end   = tick & (tph_q == spb - 5'h01);
  wire       r_samp  = tick & (rph_q == (spb >> 1) - 5'h01);
  wire       tx_load = tx_st_q == TX_IDLE & tx_full_q & (is_async ? tx_en : sync_mst);
  wire       t_last  = tx_st_q == TX_DATA & t_end & tbit_q == usart_pkg::LAST_BIT;
  wire       tx_fin  = (tx_st_q == TX_STOP & t_end) | (t_last & !is_async);

  always_ff @(posedge core_clk)
  begin
    if (chan_rst)
      div_cnt_q <= 8'h00;
    else if (clk_en)
      div_cnt_q <= tick ? 8'h00 : div_cnt_q + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter, also the shift clock source in synchronous master mode
  always_ff @(posedge core_clk)
  begin
    if (chan_rst)
    begin
      tx_st_q  <= TX_IDLE;
      tx_sh_q  <= 8'h00;
      tph_q    <= 5'h00;
      tbit_q   <= 3'h0;
      tx_par_q <= 1'b0;
      srx_q    <= 8'h00;
    end
    else if (clk_en)
    begin
      if (tx_st_q != TX_IDLE && tick)
        tph_q <= t_end ? 5'h00 : tph_q + 5'h01;
      if (tx_st_q == TX_DATA && !is_async && tick && tph_q == 5'h00)
        srx_q <= {rx_s_q, srx_q[7:1]};
      case (tx_st_q)
        TX_IDLE:
          if (tx_load)
          begin
            tx_sh_q  <= tx_buf_q;
            tph_q    <= 5'h00;
            tbit_q   <= 3'h0;
            tx_par_q <= par_odd;
            tx_st_q  <= is_async ? TX_START : TX_DATA;
          end
        TX_START:
          if (t_end)
            tx_st_q <= TX_DATA;
        TX_DATA:
          if (t_end)
          begin
            tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
            tx_par_q <= tx_par_q ^ tx_sh_q[0];
            tbit_q   <= tbit_q + 3'h1;
            if (t_last)
              tx_st_q <= !is_async ? TX_IDLE : par_en ? TX_PAR : TX_STOP;
          end
        TX_PAR:
          if (t_end)
            tx_st_q <= TX_STOP;
        TX_STOP:
          if (t_end)
            tx_st_q <= TX_IDLE;
        default:
          tx_st_q <= TX_IDLE;
      endcase
    end
  end

  logic txd_d;
  always_comb
  begin
    case (tx_st_q)
      TX_START: txd_d = 1'b0;
      TX_DATA:  txd_d = tx_sh_q[0];
      TX_PAR:   txd_d = tx_par_q;
      default:  txd_d = 1'b1;
    endcase
    if (!tx_en)
      txd_d = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver: asynchronous frame state machine, frame completion for both modes
  wire       a_done = rx_st_q == RX_STOP & r_samp;
  wire       s_done = t_last & !is_async & rxe;
  wire       f_done = a_done | s_done;
  wire [7:0] f_data = a_done ? rx_sh_q : srx_q;
  wire       f_frame_err  = a_done & !rx_s_q;
  wire       f_parity_err = a_done & rx_par_err_q;
  wire       accept = f_done & (!rx_full_q | rd_data) & (!overrun_q | rd_data);
  wire       ovr    = f_done & rx_full_q & !rd_data;

  always_ff @(posedge core_clk)
  begin
    if (chan_rst)
    begin
      rx_st_q  <= RX_IDLE;
      rx_sh_q  <= 8'h00;
      rph_q    <= 5'h00;
      rbit_q   <= 3'h0;
      rx_par_q     <= 1'b0;
      rx_par_err_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (rx_st_q != RX_IDLE && tick)
        rph_q <= (rph_q == spb - 5'h01) ? 5'h00 : rph_q + 5'h01;
      case (rx_st_q)
        RX_IDLE:
          if (is_async && rxe && !rx_s_q)
          begin
            rph_q   <= 5'h00;
            rx_st_q <= RX_START;
          end
        RX_START:
          if (r_samp)
          begin
            rbit_q   <= 3'h0;
            rx_par_q     <= par_odd;
            rx_par_err_q <= 1'b0;
            rx_st_q  <= rx_s_q ? RX_IDLE : RX_DATA;
          end
        RX_DATA:
          if (r_samp)
          begin
            rx_sh_q  <= {rx_s_q, rx_sh_q[7:1]};
            rx_par_q <= rx_par_q ^ rx_s_q;
            rbit_q   <= rbit_q + 3'h1;
            if (rbit_q == usart_pkg::LAST_BIT)
              rx_st_q <= par_en ? RX_PAR : RX_STOP;
          end
        RX_PAR:
          if (r_samp)
          begin
            rx_par_err_q <= rx_par_q ^ rx_s_q;
            rx_st_q <= RX_STOP;
          end
        RX_STOP:
          if (r_samp)
            rx_st_q <= RX_IDLE;
        default:
          rx_st_q <= RX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffers and status flags (hardware set wins over software clear)
  wire wake_set = is_async & stop_mode & !rx_s_q;
  wire stat_clr = wr_stat;

  always_ff @(posedge core_clk)
  begin
    if (chan_rst)
    begin
      rx_buf_q  <= usart_pkg::DATA_RST;
      tx_buf_q  <= usart_pkg::DATA_RST;
      rx_full_q <= 1'b0;
      tx_full_q <= 1'b0;
      tx_empty_q   <= 1'b1;
      txc_q        <= 1'b0;
      wake_q       <= 1'b0;
      overrun_q    <= 1'b0;
      frame_err_q  <= 1'b0;
      parity_err_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr_data)
        tx_buf_q <= wdata;
      tx_full_q <= wr_data | (tx_full_q & !tx_load);
      tx_empty_q <= tx_load | (tx_empty_q & !wr_data & !(stat_clr & !wdata[usart_pkg::ST_TX_EMPTY]));
      txc_q     <= (tx_fin & !tx_full_q) | (txc_q & !(stat_clr & !wdata[usart_pkg::ST_TXC]));
      wake_q    <= wake_set | (wake_q & !(stat_clr & !wdata[usart_pkg::ST_WAKE]));
      overrun_q <= ovr | (overrun_q & !rd_data);
      if (accept)
      begin
        rx_buf_q     <= f_data;
        frame_err_q  <= f_frame_err;
        parity_err_q <= f_parity_err;
      end
      else if (rd_data)
      begin
        frame_err_q  <= 1'b0;
        parity_err_q <= 1'b0;
      end
      rx_full_q <= accept | (rx_full_q & !rd_data);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts, read port, pin outputs
  wire [IRQ_W-1:0] ev = {ovr, wake_set & !wake_q, tx_load, accept};
  wire [7:0] stat_v = {tx_empty_q, txc_q, rx_full_q, wake_q, srst_q, overrun_q, frame_err_q, parity_err_q};
  wire [7:0] rmux =
    hit(addr, usart_pkg::CTRL_ADDR)     ? ctrl_q   :
    hit(addr, usart_pkg::STAT_ADDR)     ? stat_v   :
    hit(addr, usart_pkg::BAUD_ADDR)     ? baud_q   :
    hit(addr, usart_pkg::DATA_ADDR)     ? rx_buf_q :
    hit(addr, usart_pkg::IRQ_STAT_ADDR) ? 8'(irq_stat_q) :
    hit(addr, usart_pkg::IRQ_MASK_ADDR) ? 8'(irq_mask_q) : 8'h00;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      irq_stat_q <= '0;
      rdata_q    <= 8'h00;
      txd_q      <= 1'b1;
      sclk_q     <= 1'b0;
      sclk_oe_q  <= 1'b0;
      irq_q      <= 1'b0;
    end
    else if (clk_en)
    begin
      irq_stat_q <= ev | (irq_stat_q & ~(wr_istat ? wdata[IRQ_W-1:0] : '0));
      rdata_q    <= rd_en ? rmux : 8'h00;
      txd_q      <= txd_d;
      sclk_q     <= sync_mst & tx_st_q == TX_DATA & tph_q[0];
      sclk_oe_q  <= sync_mst;
      irq_q      <= |(irq_stat_q & irq_mask_q);
    end
  end

  assign rdata               = rdata_q;
  assign tx_line             = txd_q;
  assign sync_shift_clock    = sclk_q;
  assign sync_shift_clock_oe = sclk_oe_q;
  assign irq                 = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  wake_async_set_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && is_async && stop_mode && !rx_s_q && !srst_q |=> wake_q) else $error("wake flag not set");
  wake_sync_block_a: assert property (@(posedge core_clk) disable iff (reset)
    !is_async && !wake_q |=> !wake_q) else $error("wake flag set outside async mode");
  soft_reset_clear_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && srst_q |=> !srst_q && tx_empty_q && !rx_full_q && !overrun_q)
    else $error("soft reset did not self-clear");
  overrun_drop_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && overrun_q && !rd_data && !srst_q |=> overrun_q && $stable(rx_buf_q))
    else $error("frame taken during overrun");
  overrun_read_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && rd_data && !f_done |=> !overrun_q) else $error("overrun survived buffer read");
  frame_err_load_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && accept && !srst_q |=> frame_err_q == $past(f_frame_err) && rx_full_q)
    else $error("framing flag wrong");
  parity_gate_a: assert property (@(posedge core_clk) disable iff (reset)
    rx_st_q == RX_START && clk_en && r_samp && !par_en && !srst_q |=> !rx_par_err_q)
    else $error("parity error without checking");
  baud_load_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && wr_baud |=> baud_q == $past(wdata)) else $error("divisor not loaded");
  data_read_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && rd_data |=> rdata_q == $past(rx_buf_q)) else $error("data port read wrong");
  sync_start_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && tx_full_q && sync_mst && tx_st_q == TX_IDLE && !srst_q |=> tx_st_q == TX_DATA)
    else $error("shift clock not started");
  tx_empty_clear_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && wr_stat && !wdata[usart_pkg::ST_TX_EMPTY] && !tx_load && !srst_q |=> !tx_empty_q)
    else $error("empty flag not cleared");

endmodule

// ### usart_pkg.sv
// Constants for the serial channel: register offsets, field positions, reset values, modes.
// Assumes an 8-bit register port on the channel's own clock.
package usart_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] CTRL_ADDR     = 8'hE2;
  localparam logic [7:0] STAT_ADDR     = 8'hE5;
  localparam logic [7:0] BAUD_ADDR     = 8'hE6;
  localparam logic [7:0] DATA_ADDR     = 8'hE7;
  localparam logic [7:0] IRQ_STAT_ADDR = 8'hE8;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'hE9;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'hFF;
  localparam logic [7:0] DATA_RST = 8'hFF;
  localparam logic [7:0] MASK_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // channel_status bit positions
  localparam int ST_TX_EMPTY   = 7;
  localparam int ST_TXC        = 6;
  localparam int ST_RXC        = 5;
  localparam int ST_WAKE       = 4;
  localparam int ST_SRST       = 3;
  localparam int ST_OVERRUN    = 2;
  localparam int ST_FRAME_ERR  = 1;
  localparam int ST_PARITY_ERR = 0;

  // Control register bit positions
  localparam int CT_MODE_HI      = 7;
  localparam int CT_MODE_LO      = 6;
  localparam int CT_PAR_EN       = 5;
  localparam int CT_PAR_ODD      = 4;
  localparam int CT_TX_EN        = 3;
  localparam int CT_RXE          = 2;
  localparam int CT_MASTER       = 1;
  localparam int CT_DOUBLE_SPEED = 0;

  // Interrupt status and mask bit positions
  localparam int IR_RX   = 0;
  localparam int IR_TX_EMPTY = 1;
  localparam int IR_WAKE = 2;
  localparam int IR_OVR  = 3;
  localparam int IR_W    = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Operating modes and timing counts
  localparam logic [1:0] MODE_ASYNC = 2'h0;
  localparam logic [1:0] MODE_SYNC  = 2'h1;
  localparam logic [1:0] MODE_SPI   = 2'h3;

  localparam logic [4:0] OS_NORMAL = 5'h10;
  localparam logic [4:0] OS_DOUBLE = 5'h08;
  localparam logic [4:0] OS_SYNC   = 5'h02;
  localparam logic [2:0] LAST_BIT  = 3'h7;

endpackage

// ### usart_remote.sv
// Remote serial device model on the channel's receive and transmit pins.
// Assumes the channel samples core_clk; bit lengths are given in core_clk cycles.
`timescale 1ns/1ps
module usart_remote (
  input  wire logic core_clk,  // System clock
  input  wire logic tx_line,   // Serial data from the channel
  output logic      rx_line    // Serial data into the channel, idles high
);
  initial rx_line = 1'b1;

  ////////////////////////////////////////
  // Line driver
  task automatic put(input logic v, input int n);
    @(posedge core_clk);
    rx_line <= v;
    repeat (n - 1) @(posedge core_clk);
  endtask

  task automatic set_line(input logic v);
    @(posedge core_clk);
    rx_line <= v;
  endtask

  // One frame: start, eight data bits LSB first, optional even parity, one stop
  task automatic send(input logic [7:0] b, input int n, input logic par_en, input logic bad_par,
                      input logic bad_stop);
    put(1'b0, n);
    for (int i = 0; i < 8; i++)
      put(b[i], n);
    if (par_en)
      put((^b) ^ bad_par, n);
    put(~bad_stop, n);
    rx_line <= 1'b1;
  endtask

  ////////////////////////////////////////
  // Frame capture from the channel, sampled mid-bit
  task automatic recv(input int n, output logic [7:0] b, output logic ok);
    int w;
    w = 0;
    b = 8'h00;
    while (tx_line !== 1'b0 && w < 4000)
    begin
      @(posedge core_clk);
      w++;
    end
    ok = (w < 4000);
    repeat (n + n / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++)
    begin
      b[i] = tx_line;
      repeat (n) @(posedge core_clk);
    end
  endtask
endmodule
